// file: logic/cgcr_pkg.sv
// Purpose: constants for the channel and general pin register bank
// Assumes: 8-bit register address, 16-bit register data
// Notes:   pin configuration offset and sequencer dwell are local choices
package cgcr_pkg;
  // address and data widths
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam int          NUM_CH          = 8;
  // register offsets
  localparam logic [7:0]  PIN_CFG_ADDR    = 8'h06;
  localparam logic [7:0]  PART_ID_ADDR    = 8'h07;
  localparam logic [7:0]  CH_BASE_ADDR    = 8'h10;
  localparam logic [7:0]  SEQ_STAT_ADDR   = 8'h20;
  // identification code, value is arbitrary
  localparam logic [15:0] PART_ID_VALUE   = 16'h5a3c;
  // channel register fields
  localparam int          CH_EN_BIT       = 15;
  localparam int          SETUP_HI        = 14;
  localparam int          SETUP_LO        = 12;
  localparam int          RSVD_HI         = 11;
  localparam int          RSVD_LO         = 10;
  localparam int          POS_HI          = 9;
  localparam int          POS_LO          = 5;
  localparam int          NEG_HI          = 4;
  localparam int          NEG_LO          = 0;
  localparam logic [15:0] CH_WR_MASK      = 16'hf3ff;
  localparam logic [15:0] CH0_RESET       = 16'h8001;
  localparam logic [15:0] CHN_RESET       = 16'h0001;
  // pin configuration fields
  localparam int          PIN0_IN_EN_BIT  = 4;
  localparam int          PIN1_OUT_EN_BIT = 3;
  localparam int          PIN0_OUT_EN_BIT = 2;
  localparam int          PIN1_LVL_BIT    = 1;
  localparam int          PIN0_LVL_BIT    = 0;
  localparam logic [4:0]  PIN_CFG_RESET   = 5'h00;
  // conversion slot length per channel while sequencing
  localparam int          DWELL_NS        = 1000;
  localparam int          CLK_NS          = 25;
  localparam int          DWELL_CYCLES    = (DWELL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  DWELL_LAST      = 8'(DWELL_CYCLES - 1);
  // sequencer states
  typedef enum logic [0:0] {CGCR_IDLE, CGCR_CONVERT} cgcr_seq_e;
endpackage : cgcr_pkg

// file: logic/cgcr_regs.sv
// Purpose: channel and general pin register bank of a multiplexed converter
// Assumes: one clock, synchronous active-low reset, plain register port
// Notes:   read data appear the cycle after the read strobe only
//
// Behaviour
// - bit 4 makes pin zero input
// - bit 3 makes pin one output
// - bit 2 makes pin zero output
// - bit 1 pin one level, reads pin
// - bit 0 pin zero level, reads pin
// - read-only identification register at 0x07
// - channel registers sixteen bits wide
// - channel zero at 0x10, resets 0x8001
// - bit 15 enables its channel
// - multiple enabled channels sequence automatically
// - bits 14:12 select setup zero..seven
// - setup is four registers applied together; this bank holds none of them and only puts out the code on setup_choice
// - bits 11:10 reserved, read zero
// - bits 9:5 positive input select
// - bits 4:0 negative input, reset one
// - channels one..seven follow, reset 0x0001
`timescale 1ns/1ps
`default_nettype none
module cgcr_regs (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic [cgcr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cgcr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [cgcr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        general_pin_zero_in,
  output var  logic                        general_pin_zero_out,
  output var  logic                        general_pin_zero_oe_n,
  input  wire logic                        general_pin_one_in,
  output var  logic                        general_pin_one_out,
  output var  logic                        general_pin_one_oe_n,
  output var  logic                        channel_active,
  output var  logic [2:0]                  active_channel,
  output var  logic [2:0]                  setup_choice,
  output var  logic [4:0]                  positive_input_select,
  output var  logic [4:0]                  negative_input_select
);
  import cgcr_pkg::*;

  logic [DATA_W-1:0] chan_cfg [NUM_CH];   // channel registers
  logic [4:0]        pin_cfg;             // pin configuration, low five bits
  logic [NUM_CH-1:0] ch_enable;           // enable bit of each channel
  logic [NUM_CH-1:0] ch_hit;              // address decode per channel
  logic              pin_hit;             // pin configuration decode
  logic              id_hit;              // identification decode
  logic              stat_hit;            // sequencer status decode
  logic              ch_space;            // address in channel window
  logic [2:0]        ch_idx;              // channel index from address
  logic [2:0]        seq_ch;              // channel being converted
  logic              seq_busy;            // sequencer running
  logic [DATA_W-1:0] pin_read;            // pin register read image
  logic [DATA_W-1:0] next_rdata;          // selected read data
  logic [DATA_W-1:0] cur_cfg;             // register of converting channel
  logic              pin0_level_rd;       // level seen on pin zero
  logic              pin1_level_rd;       // level seen on pin one

  // address decode
  assign ch_space = (reg_addr >= CH_BASE_ADDR) &&
                    (reg_addr <  8'(CH_BASE_ADDR + 8'(NUM_CH)));
  assign ch_idx   = 3'(reg_addr - CH_BASE_ADDR);
  assign pin_hit  = (reg_addr == PIN_CFG_ADDR);
  assign id_hit   = (reg_addr == PART_ID_ADDR);
  assign stat_hit = (reg_addr == SEQ_STAT_ADDR);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      assign ch_hit[g]    = ch_space && (ch_idx == 3'(g));
      assign ch_enable[g] = chan_cfg[g][CH_EN_BIT];
      // one register per channel
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          chan_cfg[g] <= (g == 0) ? CH0_RESET : CHN_RESET;
        end else if (reg_wr && ch_hit[g]) begin
          chan_cfg[g] <= reg_wdata & CH_WR_MASK;
        end
      end
    end
  endgenerate

  // pin configuration register; write lands all five bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_cfg <= PIN_CFG_RESET;
    end else if (reg_wr && pin_hit) begin
      pin_cfg <= reg_wdata[4:0];
    end
  end

  // pin one reads pin when its output is not enabled
  assign pin1_level_rd = pin_cfg[PIN1_OUT_EN_BIT] ? pin_cfg[PIN1_LVL_BIT] :
                         general_pin_one_in;
  assign pin0_level_rd = pin_cfg[PIN0_IN_EN_BIT] ? general_pin_zero_in :
                         pin_cfg[PIN0_LVL_BIT];
  // read image; pin one has no input enable here so it follows the pin when not driven
  assign pin_read = {11'h000,
                     pin_cfg[PIN0_IN_EN_BIT],
                     pin_cfg[PIN1_OUT_EN_BIT],
                     pin_cfg[PIN0_OUT_EN_BIT],
                     pin1_level_rd,
                     pin0_level_rd};

  assign next_rdata = id_hit   ? PART_ID_VALUE :
                      pin_hit  ? pin_read :
                      ch_space ? chan_cfg[ch_idx] :
                      stat_hit ? {12'h000, seq_busy, seq_ch} :
                      16'h0000;

  // read port: data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  cgcr_sequencer u_seq (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .ch_enable  (ch_enable),
    .active_ch  (seq_ch),
    .converting (seq_busy)
  );

  assign cur_cfg = chan_cfg[seq_ch];

  // drive the converter selects from the channel in conversion
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      channel_active        <= 1'b0;
      active_channel        <= 3'h0;
      setup_choice          <= 3'h0;
      positive_input_select <= 5'h00;
      negative_input_select <= 5'h01;
    end else begin
      channel_active        <= seq_busy;
      active_channel        <= seq_ch;
      setup_choice          <= cur_cfg[SETUP_HI:SETUP_LO];
      positive_input_select <= cur_cfg[POS_HI:POS_LO];
      negative_input_select <= cur_cfg[NEG_HI:NEG_LO];
    end
  end

  // pin drivers; output enable is low while driving
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      general_pin_zero_out  <= 1'b0;
      general_pin_zero_oe_n <= 1'b1;
      general_pin_one_out   <= 1'b0;
      general_pin_one_oe_n  <= 1'b1;
    end else begin
      general_pin_zero_oe_n <= ~pin_cfg[PIN0_OUT_EN_BIT];
      general_pin_zero_out  <= pin_cfg[PIN0_LVL_BIT];
      general_pin_one_oe_n  <= ~pin_cfg[PIN1_OUT_EN_BIT];
      general_pin_one_out   <= pin_cfg[PIN1_LVL_BIT];
    end
  end

  // pin zero input enable only changes the readback, never the drive
endmodule : cgcr_regs
`default_nettype wire

// file: logic/cgcr_sequencer.sv
// Purpose: steps through enabled channels, one dwell slot each
// Assumes: enable mask comes from the channel registers
// Notes:   a slot always completes before the next channel is picked
`timescale 1ns/1ps
`default_nettype none
module cgcr_sequencer (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic [cgcr_pkg::NUM_CH-1:0] ch_enable,
  output var  logic [2:0]              active_ch,
  output var  logic                    converting
);
  import cgcr_pkg::*;

  cgcr_seq_e  state;       // sequencer state
  logic [7:0] dwell;       // cycles spent on current channel
  logic [2:0] next_ch;     // next enabled channel after active_ch
  logic       any_en;      // at least one channel enabled
  logic       slot_done;   // dwell slot ends this cycle

  assign any_en    = |ch_enable;
  assign slot_done = (dwell == DWELL_LAST);

  // round-robin search from the channel after the current one
  always_comb begin
    next_ch = active_ch;
    for (int k = NUM_CH; k >= 1; k--) begin
      if (ch_enable[3'(active_ch + 3'(k))]) begin
        next_ch = 3'(active_ch + 3'(k));
      end
    end
  end

  // slot timing and channel stepping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state      <= CGCR_IDLE;
      dwell      <= 8'h00;
      active_ch  <= 3'h0;
      converting <= 1'b0;
    end else begin
      case (state)
        // wait for any channel, then start on it
        CGCR_IDLE: begin
          dwell <= 8'h00;
          if (any_en) begin
            active_ch  <= next_ch;
            state      <= CGCR_CONVERT;
            converting <= 1'b1;
          end
        end
        CGCR_CONVERT: begin
          dwell <= slot_done ? 8'h00 : 8'(dwell + 8'h01);
          if (slot_done) begin
            if (any_en) begin
              active_ch <= next_ch;
            end else begin
              state      <= CGCR_IDLE;
              converting <= 1'b0;
            end
          end
        end
        default: begin
          state      <= CGCR_IDLE;
          converting <= 1'b0;
        end
      endcase
    end
  end
endmodule : cgcr_sequencer
`default_nettype wire

// file: testbench/cgcr_regs_sva.sv
// Purpose: port checks of the register bank
// Assumes: one clock, sync active-low reset
// Notes:   pin outputs settle two edges after the write strobe
`timescale 1ns/1ps
`default_nettype none
module cgcr_regs_sva (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire logic [cgcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cgcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [cgcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        general_pin_zero_out,
  input wire logic                        general_pin_zero_oe_n,
  input wire logic                        general_pin_one_out,
  input wire logic                        general_pin_one_oe_n,
  input wire logic                        channel_active,
  input wire logic [2:0]                  active_channel,
  input wire logic [4:0]                  negative_input_select
);
  import cgcr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // pin register writes, named once for the four pin checks
  wire pin_wr = reg_wr && (reg_addr == PIN_CFG_ADDR);
  a_idle_rdata_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_id_value: assert property (reg_rd && reg_addr == PART_ID_ADDR |=>
    reg_rdata == PART_ID_VALUE) else $error("identification value wrong");
  a_rsvd_zero: assert property (reg_rd && reg_addr[7:3] == 5'h02 |=>
    reg_rdata[11:10] == 2'b00) else $error("reserved channel bits not zero");
  a_pin0_drive_en: assert property (pin_wr |-> ##2
    general_pin_zero_oe_n == !$past(reg_wdata[2], 2)) else $error("pin zero enable wrong");
  a_pin1_drive_en: assert property (pin_wr |-> ##2
    general_pin_one_oe_n == !$past(reg_wdata[3], 2)) else $error("pin one enable wrong");
  a_pin0_level: assert property (pin_wr |-> ##2
    general_pin_zero_out == $past(reg_wdata[0], 2)) else $error("pin zero level wrong");
  a_pin1_level: assert property (pin_wr |-> ##2
    general_pin_one_out == $past(reg_wdata[1], 2)) else $error("pin one level wrong");
  // a slot lasts far longer than eight cycles, so a quick hop is a fault
  a_dwell_hold: assert property ($changed(active_channel) |=>
    $stable(active_channel)[*8]) else $error("channel slot cut short");
  a_neg_reset: assert property ($rose(rst_n) |-> negative_input_select == 5'h01)
    else $error("negative selector reset wrong");
  c_id_read: cover property (reg_rd && reg_addr == PART_ID_ADDR);
  c_pin_write: cover property (pin_wr);
  c_channel_step: cover property ($changed(active_channel) && channel_active);
endmodule : cgcr_regs_sva
bind cgcr_regs cgcr_regs_sva chk_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .general_pin_zero_out(general_pin_zero_out), .general_pin_zero_oe_n(general_pin_zero_oe_n),
  .general_pin_one_out(general_pin_one_out), .general_pin_one_oe_n(general_pin_one_oe_n),
  .channel_active(channel_active), .active_channel(active_channel),
  .negative_input_select(negative_input_select));
`default_nettype wire

// file: testbench/tb_cgcr_regs.sv
// Purpose: self-checking bench of the register bank
// Assumes: 40 MHz clock, sync active-low reset
// Notes:   an array model mirrors the channel registers
`timescale 1ns/1ps
`default_nettype none
module tb_cgcr_regs;
  import cgcr_pkg::*;
  logic        core_clk;
  logic        rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, p0_in = 1'b0, p1_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        p0_out, p0_oe_n, p1_out, p1_oe_n, ch_act;
  logic [2:0]  act_ch, setup;
  logic [4:0]  pos_sel, neg_sel, pin_m;
  logic [15:0] ch_m [8];
  logic [31:0] seed = 32'h0000_0e8a;
  int          n_fail = 0, checks_done = 0, cyc = 0, i, seen0 = 0, seen5 = 0;
  cgcr_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .general_pin_zero_in(p0_in), .general_pin_zero_out(p0_out),
    .general_pin_zero_oe_n(p0_oe_n), .general_pin_one_in(p1_in),
    .general_pin_one_out(p1_out), .general_pin_one_oe_n(p1_oe_n), .channel_active(ch_act),
    .active_channel(act_ch), .setup_choice(setup), .positive_input_select(pos_sel),
    .negative_input_select(neg_sel));
  // free-running 25 ns clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // read answer is looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // pin zero reads the pin when input enabled, pin one when not driven
  function automatic logic [15:0] pin_rd();
    return {11'h0, pin_m[4:2], pin_m[3] ? pin_m[1] : p1_in, pin_m[4] ? p0_in : pin_m[0]};
  endfunction : pin_rd
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++) ch_m[i] = (i == 0) ? CH0_RESET : CHN_RESET;
    for (i = 0; i < 8; i++) rd(CH_BASE_ADDR + 8'(i), ch_m[i]);
    rd(PIN_CFG_ADDR, 16'h0000);
    wr(PART_ID_ADDR, 16'(xs()));
    rd(PART_ID_ADDR, PART_ID_VALUE);
    rd(8'h3f, 16'h0000);
    // every setup code, random fields, reserved bits masked
    for (i = 0; i < 24; i++) begin
      // software keeps reserved bits zero on writes
      ch_m[i % 8] = 16'(xs()) & CH_WR_MASK;
      ch_m[i % 8][14:12] = 3'(i);
      wr(CH_BASE_ADDR + 8'(i % 8), ch_m[i % 8]);
      rd(CH_BASE_ADDR + 8'(i % 8), ch_m[i % 8]);
    end
    // two enabled channels take turns with their own fields
    // each active channel keeps its own setup code
    for (i = 0; i < 8; i++) begin
      ch_m[i][15] = (i == 0 || i == 5);
      wr(CH_BASE_ADDR + 8'(i), ch_m[i]);
    end
    repeat (100) @(posedge core_clk);
    for (i = 0; i < 400; i++) begin
      @(posedge core_clk);
      #1 if (ch_act === 1'b1) begin
        chk({2'b0, ch_m[act_ch][15], setup, pos_sel, neg_sel},
          {3'b001, ch_m[act_ch][14:12], ch_m[act_ch][9:0]});
        seen0 = seen0 + (act_ch === 3'd0);
        seen5 = seen5 + (act_ch === 3'd5);
      end
    end
    chk(16'(seen0 > 0 && seen5 > 0), 16'h0001);
    // all enable and level combinations, random pin levels
    for (i = 0; i < 32; i++) begin
      {p0_in, p1_in} <= 2'(xs());
      pin_m = 5'(i);
      wr(PIN_CFG_ADDR, {11'(xs()), pin_m});
      @(posedge core_clk);
      #1 chk({p1_oe_n, p0_oe_n, p1_out, p0_out}, {~pin_m[3:2], pin_m[1:0]});
      rd(PIN_CFG_ADDR, pin_rd());
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CH_BASE_ADDR, CH0_RESET);
    rd(PIN_CFG_ADDR, {11'h0, 3'b000, p1_in, 1'b0});
    rd(SEQ_STAT_ADDR, 16'h0008);
    test_done();
  end
endmodule : tb_cgcr_regs
`default_nettype wire
